// file: endpoint_cfg_if.sv
// Interface carrying register access and selected-endpoint settings.
`timescale 1ns/1ps
`default_nettype none
interface endpoint_cfg_if;
    logic wr_en;
    logic [endpoint_config_pkg::ADDR_W-1:0] addr;
    logic [endpoint_config_pkg::DATA_W-1:0] wdata;
    logic [endpoint_config_pkg::IDX_W-1:0] index;
    logic [endpoint_config_pkg::DATA_W-1:0] packet_size_word;
    logic [endpoint_config_pkg::DATA_W-1:0] type_control_word;
    modport master
    (
        output wr_en,
        output addr,
        output wdata,
        output index,
        input packet_size_word,
        input type_control_word
    );
    modport bank
    (
        input wr_en,
        input addr,
        input wdata,
        input index,
        output packet_size_word,
        output type_control_word
    );
endinterface : endpoint_cfg_if
`default_nettype wire

// file: endpoint_cfg_store.sv
// Per-endpoint storage of the packet size and type control words.
`timescale 1ns/1ps
`default_nettype none
module endpoint_cfg_store
(
    input wire logic CLK_SYS_I,
    input wire logic RST_I,
    endpoint_cfg_if.bank cfg
);
    logic [endpoint_config_pkg::DATA_W-1:0] size_mem_reg [endpoint_config_pkg::NUM_EP];
    logic [endpoint_config_pkg::DATA_W-1:0] type_mem_reg [endpoint_config_pkg::NUM_EP];

    always_ff @(posedge CLK_SYS_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            for (int i = 0; i < endpoint_config_pkg::NUM_EP; i++)
            begin
                size_mem_reg[i] <= endpoint_config_pkg::RESET_VALUE;
            end
        end
        else if (cfg.wr_en && cfg.addr == endpoint_config_pkg::OFS_PACKET_SIZE
                 && cfg.index != endpoint_config_pkg::CONTROL_EP_INDEX)
        begin
            size_mem_reg[cfg.index] <= cfg.wdata & endpoint_config_pkg::PACKET_SIZE_MASK;
        end
    end

    always_ff @(posedge CLK_SYS_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            for (int i = 0; i < endpoint_config_pkg::NUM_EP; i++)
            begin
                type_mem_reg[i] <= endpoint_config_pkg::RESET_VALUE;
            end
        end
        else if (cfg.wr_en && cfg.addr == endpoint_config_pkg::OFS_TYPE_CONTROL)
        begin
            type_mem_reg[cfg.index] <= cfg.wdata & endpoint_config_pkg::TYPE_CONTROL_MASK;
        end
    end

    assign cfg.packet_size_word = size_mem_reg[cfg.index];
    assign cfg.type_control_word = type_mem_reg[cfg.index];
endmodule : endpoint_cfg_store
`default_nettype wire

// file: endpoint_config_pkg.sv
// Constants and types for the per-endpoint configuration registers.
// Overview of operation
// - Writing the packet size register reloads the indexed endpoint's buffer length count.
// - Packet size register holds a separate setting per endpoint, excluding control zero.
// - Transactions field: 00 one, 01 two, 10 three packets; 11 reserved.
// - Transactions setting applies only to high-speed isochronous or interrupt endpoints.
// - Eleven-bit FIFO size field gives buffer bytes at full and high speed.
// - Suppress bit clear sends zero-length packet after DMA IN; set sends none.
// - Enable bit set enables and allocates the endpoint FIFO; clear disables it.
// - Disabling then re-enabling a stalled endpoint resets its data toggle.
// - Double buffer bit set selects double buffering; clear selects single.
// - Type field: 00 unused, 01 isochronous, 10 bulk, 11 interrupt.
// - Bus reset clears every endpoint's buffer length count to zero.
package endpoint_config_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;
    localparam int IDX_W = 4;
    localparam int NUM_EP = 16;
    localparam logic [ADDR_W-1:0] OFS_PACKET_SIZE = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_TYPE_CONTROL = 8'h08;
    localparam int FIFO_SIZE_LSB = 0;
    localparam int FIFO_SIZE_W = 11;
    localparam int TRANS_LSB = 11;
    localparam int TRANS_W = 2;
    localparam int TYPE_LSB = 0;
    localparam int TYPE_W = 2;
    localparam int DBL_BIT = 2;
    localparam int ENABLE_BIT = 3;
    localparam int NOZLP_BIT = 4;
    localparam logic [DATA_W-1:0] PACKET_SIZE_MASK = 16'h1fff;
    localparam logic [DATA_W-1:0] TYPE_CONTROL_MASK = 16'h001f;
    localparam logic [DATA_W-1:0] RESET_VALUE = 16'h0000;
    localparam logic [IDX_W-1:0] CONTROL_EP_INDEX = 4'h0;
    localparam int BUFFER_TOTAL_BYTES = 8192;

    typedef enum logic [1:0]
    {
        EP_UNUSED = 2'b00,
        EP_ISOCHRONOUS = 2'b01,
        EP_BULK = 2'b10,
        EP_INTERRUPT = 2'b11
    } ep_transfer_type;

    typedef enum logic [1:0]
    {
        TRANS_ONE = 2'b00,
        TRANS_TWO = 2'b01,
        TRANS_THREE = 2'b10,
        TRANS_RESERVED = 2'b11
    } trans_code_type;
endpackage : endpoint_config_pkg

// file: endpoint_config_regs.sv
// Register bank for per-endpoint packet size and type control.
`timescale 1ns/1ps
`default_nettype none
module endpoint_config_regs
(
    input wire logic CLK_SYS_I,
    input wire logic RST_I,
    input wire logic BUS_RESET_I,
    input wire logic HIGH_SPEED_I,
    input wire logic [endpoint_config_pkg::IDX_W-1:0] EP_INDEX_I,
    input wire logic WR_EN_I,
    input wire logic RD_EN_I,
    input wire logic [endpoint_config_pkg::ADDR_W-1:0] ADDR_I,
    input wire logic [endpoint_config_pkg::DATA_W-1:0] WDATA_I,
    input wire logic LEN_WR_I,
    input wire logic [endpoint_config_pkg::DATA_W-1:0] LEN_WDATA_I,
    input wire logic DMA_IN_DONE_I,
    input wire logic IN_TOKEN_I,
    input wire logic [endpoint_config_pkg::IDX_W-1:0] TOKEN_EP_I,
    output logic [endpoint_config_pkg::DATA_W-1:0] RDATA_O,
    output logic [endpoint_config_pkg::DATA_W-1:0] BUFFER_LENGTH_COUNT_O,
    output logic [endpoint_config_pkg::FIFO_SIZE_W-1:0] FIFO_SIZE_BYTES_O,
    output logic [1:0] PACKETS_PER_MICROFRAME_O,
    output logic [1:0] ENDPOINT_TRANSFER_TYPE_O,
    output logic ENDPOINT_ENABLE_O,
    output logic DOUBLE_BUFFER_ENABLE_O,
    output logic [endpoint_config_pkg::NUM_EP-1:0] FIFO_ALLOCATED_O,
    output logic [endpoint_config_pkg::NUM_EP-1:0] TOGGLE_RESET_O,
    output logic SEND_ZERO_LENGTH_O
);
    endpoint_cfg_if cfg ();

    logic [endpoint_config_pkg::DATA_W-1:0] count_mem_reg [endpoint_config_pkg::NUM_EP];
    logic [endpoint_config_pkg::NUM_EP-1:0] enable_reg;
    logic [endpoint_config_pkg::NUM_EP-1:0] enable_next;
    logic [endpoint_config_pkg::NUM_EP-1:0] zlp_pending_reg;
    logic [endpoint_config_pkg::DATA_W-1:0] size_word;
    logic [endpoint_config_pkg::DATA_W-1:0] type_word;
    logic [endpoint_config_pkg::TRANS_W-1:0] trans_field;
    logic [endpoint_config_pkg::TYPE_W-1:0] type_field;
    logic size_write;
    logic type_write;

    function automatic logic [endpoint_config_pkg::DATA_W-1:0] pick_read
    (
        input logic [endpoint_config_pkg::ADDR_W-1:0] a,
        input logic [endpoint_config_pkg::DATA_W-1:0] s,
        input logic [endpoint_config_pkg::DATA_W-1:0] t
    );
        case (a)
            endpoint_config_pkg::OFS_PACKET_SIZE: pick_read = s;
            endpoint_config_pkg::OFS_TYPE_CONTROL: pick_read = t;
            default: pick_read = endpoint_config_pkg::RESET_VALUE;
        endcase
    endfunction : pick_read

    assign cfg.wr_en = WR_EN_I;
    assign cfg.addr = ADDR_I;
    assign cfg.wdata = WDATA_I;
    assign cfg.index = EP_INDEX_I;
    assign size_word = cfg.packet_size_word;
    assign type_word = cfg.type_control_word;
    assign trans_field =
        size_word[endpoint_config_pkg::TRANS_LSB +: endpoint_config_pkg::TRANS_W];
    assign type_field =
        type_word[endpoint_config_pkg::TYPE_LSB +: endpoint_config_pkg::TYPE_W];

    endpoint_cfg_store u_store
    (
        .CLK_SYS_I(CLK_SYS_I),
        .RST_I(RST_I),
        .cfg(cfg)
    );

    assign size_write = WR_EN_I && ADDR_I == endpoint_config_pkg::OFS_PACKET_SIZE
                        && EP_INDEX_I != endpoint_config_pkg::CONTROL_EP_INDEX;
    assign type_write = WR_EN_I && ADDR_I == endpoint_config_pkg::OFS_TYPE_CONTROL;

    always_ff @(posedge CLK_SYS_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            for (int i = 0; i < endpoint_config_pkg::NUM_EP; i++)
            begin
                count_mem_reg[i] <= endpoint_config_pkg::RESET_VALUE;
            end
        end
        else if (BUS_RESET_I)
        begin
            for (int i = 0; i < endpoint_config_pkg::NUM_EP; i++)
            begin
                count_mem_reg[i] <= endpoint_config_pkg::RESET_VALUE;
            end
        end
        else if (size_write)
        begin
            count_mem_reg[EP_INDEX_I] <= {5'h00, WDATA_I[endpoint_config_pkg::FIFO_SIZE_W-1:0]};
        end
        else if (LEN_WR_I)
        begin
            count_mem_reg[EP_INDEX_I] <= LEN_WDATA_I;
        end
    end

    always_comb
    begin
        enable_next = enable_reg;
        if (type_write)
        begin
            enable_next[EP_INDEX_I] = WDATA_I[endpoint_config_pkg::ENABLE_BIT];
        end
    end

    always_ff @(posedge CLK_SYS_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            enable_reg <= '0;
            TOGGLE_RESET_O <= '0;
        end
        else
        begin
            enable_reg <= enable_next;
            TOGGLE_RESET_O <= enable_next & ~enable_reg;
        end
    end

    always_ff @(posedge CLK_SYS_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            zlp_pending_reg <= '0;
            SEND_ZERO_LENGTH_O <= 1'b0;
        end
        else
        begin
            SEND_ZERO_LENGTH_O <= 1'b0;
            if (IN_TOKEN_I && zlp_pending_reg[TOKEN_EP_I])
            begin
                zlp_pending_reg[TOKEN_EP_I] <= 1'b0;
                SEND_ZERO_LENGTH_O <= 1'b1;
            end
            if (DMA_IN_DONE_I && !type_word[endpoint_config_pkg::NOZLP_BIT])
            begin
                zlp_pending_reg[EP_INDEX_I] <= 1'b1;
            end
        end
    end

    always_ff @(posedge CLK_SYS_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            RDATA_O <= endpoint_config_pkg::RESET_VALUE;
        end
        else if (RD_EN_I)
        begin
            RDATA_O <= pick_read(ADDR_I, size_word, type_word);
        end
    end

    always_ff @(posedge CLK_SYS_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            BUFFER_LENGTH_COUNT_O <= endpoint_config_pkg::RESET_VALUE;
        end
        else
        begin
            BUFFER_LENGTH_COUNT_O <= count_mem_reg[EP_INDEX_I];
        end
    end

    always_ff @(posedge CLK_SYS_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            FIFO_SIZE_BYTES_O <= '0;
        end
        else
        begin
            FIFO_SIZE_BYTES_O <= size_word[endpoint_config_pkg::FIFO_SIZE_W-1:0];
        end
    end

    // Transactions field only reaches the link for high-speed periodic endpoints
    always_ff @(posedge CLK_SYS_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            PACKETS_PER_MICROFRAME_O <= endpoint_config_pkg::TRANS_ONE;
        end
        else if (HIGH_SPEED_I && (type_field == endpoint_config_pkg::EP_ISOCHRONOUS
                 || type_field == endpoint_config_pkg::EP_INTERRUPT))
        begin
            PACKETS_PER_MICROFRAME_O <= trans_field;
        end
        else
        begin
            PACKETS_PER_MICROFRAME_O <= endpoint_config_pkg::TRANS_ONE;
        end
    end

    always_ff @(posedge CLK_SYS_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            ENDPOINT_TRANSFER_TYPE_O <= 2'h0;
        end
        else
        begin
            ENDPOINT_TRANSFER_TYPE_O <= type_field;
        end
    end

    always_ff @(posedge CLK_SYS_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            DOUBLE_BUFFER_ENABLE_O <= 1'b0;
        end
        else
        begin
            DOUBLE_BUFFER_ENABLE_O <= type_word[endpoint_config_pkg::DBL_BIT];
        end
    end

    always_ff @(posedge CLK_SYS_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            ENDPOINT_ENABLE_O <= 1'b0;
        end
        else
        begin
            ENDPOINT_ENABLE_O <= enable_reg[EP_INDEX_I];
        end
    end

    // Per-endpoint view of the enables for the buffer memory allocator
    always_ff @(posedge CLK_SYS_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            FIFO_ALLOCATED_O <= '0;
        end
        else
        begin
            FIFO_ALLOCATED_O <= enable_reg;
        end
    end
endmodule : endpoint_config_regs
`default_nettype wire

// file: endpoint_config_regs_asserts.sv
// Port assertions for the endpoint configuration register bank.
`timescale 1ns/1ps
`default_nettype none
module endpoint_config_regs_asserts
(
    input wire logic CLK_SYS_I,
    input wire logic RST_I,
    input wire logic BUS_RESET_I,
    input wire logic WR_EN_I,
    input wire logic RD_EN_I,
    input wire logic LEN_WR_I,
    input wire logic IN_TOKEN_I,
    input wire logic SEND_ZERO_LENGTH_O,
    input wire logic [3:0] EP_INDEX_I,
    input wire logic [7:0] ADDR_I,
    input wire logic [15:0] WDATA_I,
    input wire logic [15:0] RDATA_O,
    input wire logic [15:0] BUFFER_LENGTH_COUNT_O,
    input wire logic [1:0] PACKETS_PER_MICROFRAME_O,
    input wire logic [1:0] ENDPOINT_TRANSFER_TYPE_O,
    input wire logic [15:0] TOGGLE_RESET_O
);
    default clocking @(posedge CLK_SYS_I); endclocking
    default disable iff (RST_I);
    property p_reload; (WR_EN_I && ADDR_I == 8'h04 && EP_INDEX_I != 4'h0 && !BUS_RESET_I) ##1
        (!WR_EN_I && !LEN_WR_I && !BUS_RESET_I && $stable(EP_INDEX_I)) [*3]
        |-> BUFFER_LENGTH_COUNT_O == ($past(WDATA_I, 3) & 16'h07ff); endproperty
    a_reload: assert property (p_reload) else $error("count not reloaded");
    property p_size_res; (RD_EN_I && ADDR_I == 8'h04) ##1 !RD_EN_I |=> RDATA_O[15:13] == 3'h0;
    endproperty
    a_size_res: assert property (p_size_res) else $error("size reserved bits set");
    property p_type_res; (RD_EN_I && ADDR_I == 8'h08) ##1 !RD_EN_I |=> RDATA_O[15:5] == 11'h000;
    endproperty
    a_type_res: assert property (p_type_res) else $error("type reserved bits set");
    property p_ep0; (RD_EN_I && ADDR_I == 8'h04 && EP_INDEX_I == 4'h0) ##1 !RD_EN_I
        |=> RDATA_O == 16'h0000; endproperty
    a_ep0: assert property (p_ep0) else $error("control endpoint size not zero");
    property p_trans; PACKETS_PER_MICROFRAME_O != 2'b00 |-> ENDPOINT_TRANSFER_TYPE_O[0]; endproperty
    a_trans: assert property (p_trans) else $error("transactions on wrong type");
    property p_toggle; TOGGLE_RESET_O != 16'h0000 |-> TOGGLE_RESET_O == 16'h0001 << $past(EP_INDEX_I)
        && $past(WR_EN_I) && $past(ADDR_I) == 8'h08 && ($past(WDATA_I) & 16'h0008) != 16'h0000;
    endproperty
    a_toggle: assert property (p_toggle) else $error("toggle reset without enable");
    property p_zlp; SEND_ZERO_LENGTH_O |-> $past(IN_TOKEN_I) ##1 !SEND_ZERO_LENGTH_O; endproperty
    a_zlp: assert property (p_zlp) else $error("empty packet not on token");
    property p_bus_reset; BUS_RESET_I [*2] |=> BUFFER_LENGTH_COUNT_O == 16'h0000; endproperty
    a_bus_reset: assert property (p_bus_reset) else $error("count kept on bus reset");
    c_size: cover property (WR_EN_I && ADDR_I == 8'h04);
    c_toggle: cover property (TOGGLE_RESET_O != 16'h0000);
    c_zlp: cover property (SEND_ZERO_LENGTH_O);
endmodule : endpoint_config_regs_asserts
bind endpoint_config_regs endpoint_config_regs_asserts u_asserts (.CLK_SYS_I, .RST_I,
    .BUS_RESET_I, .WR_EN_I, .RD_EN_I, .LEN_WR_I, .IN_TOKEN_I, .SEND_ZERO_LENGTH_O, .EP_INDEX_I,
    .ADDR_I, .WDATA_I, .RDATA_O, .BUFFER_LENGTH_COUNT_O, .PACKETS_PER_MICROFRAME_O,
    .ENDPOINT_TRANSFER_TYPE_O, .TOGGLE_RESET_O);
`default_nettype wire

// file: endpoint_config_regs_test.sv
// Self-checking bench for the endpoint configuration register bank.
`timescale 1ns/1ps
`default_nettype none
module endpoint_config_regs_test;
    logic clk_sys = 1'b0, rst = 1'b1, bus_reset = 1'b0, high_speed = 1'b1, wr_en = 1'b0;
    logic rd_en = 1'b0, len_wr = 1'b0, dma_done = 1'b0, in_token = 1'b0, rd_q = 1'b0;
    logic ep_enable, dbl_en, zlp;
    logic [1:0] packets, ep_type;
    logic [3:0] ep_index = 4'h0, token_ep = 4'h2;
    logic [7:0] addr = 8'h00;
    logic [10:0] fifo_size;
    logic [15:0] wdata = 16'h0000, len_wdata = 16'h0123, rdata, count, allocated, toggle, tword;
    logic [15:0] toggle_seen = 16'h0000, zlps = 16'h0000;
    logic [15:0] sizes [16] = '{default: 16'h0000};
    logic [15:0] exp_q [$];
    logic [31:0] seed = 32'he470;
    int miscompares = 0, num_checks = 0, cycles = 0;
    endpoint_config_regs dut
    (
        .CLK_SYS_I(clk_sys), .RST_I(rst), .BUS_RESET_I(bus_reset), .HIGH_SPEED_I(high_speed),
        .EP_INDEX_I(ep_index), .WR_EN_I(wr_en), .RD_EN_I(rd_en), .ADDR_I(addr), .WDATA_I(wdata),
        .LEN_WR_I(len_wr), .LEN_WDATA_I(len_wdata), .DMA_IN_DONE_I(dma_done),
        .IN_TOKEN_I(in_token), .TOKEN_EP_I(token_ep), .RDATA_O(rdata),
        .BUFFER_LENGTH_COUNT_O(count), .FIFO_SIZE_BYTES_O(fifo_size),
        .PACKETS_PER_MICROFRAME_O(packets), .ENDPOINT_TRANSFER_TYPE_O(ep_type),
        .ENDPOINT_ENABLE_O(ep_enable), .DOUBLE_BUFFER_ENABLE_O(dbl_en),
        .FIFO_ALLOCATED_O(allocated), .TOGGLE_RESET_O(toggle), .SEND_ZERO_LENGTH_O(zlp)
    );
    initial forever #12.5 clk_sys = ~clk_sys;
    function automatic logic [31:0] xorshift(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xorshift
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask : cyc
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("FAIL at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // Index is set one cycle ahead of the strobe, as software must do
    task automatic acc(input int e, input logic r, input logic [7:0] a, input logic [15:0] d);
        ep_index = 4'(e);
        cyc(1);
        {rd_en, wr_en, addr, wdata} = {r, !r, a, d};
        if (r)
            exp_q.push_back(d);
        cyc(1);
        {rd_en, wr_en} = 2'b00;
        cyc(1);
    endtask : acc
    task automatic fire(input logic [1:0] v);
        {dma_done, in_token} = v;
        cyc(1);
        {dma_done, in_token} = 2'b00;
        cyc(2);
    endtask : fire
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : print_verdict
    always @(posedge clk_sys)
        rd_q <= rd_en;
    // Output watcher: read results against the oldest note, pulse tallies, hang limit
    always @(negedge clk_sys)
    begin
        toggle_seen = toggle_seen | toggle;
        zlps = zlps + 16'(zlp === 1'b1);
        cycles++;
        if (rd_q)
            chk(rdata, exp_q.pop_front());
        if (cycles == 5000)
        begin
            miscompares++;
            print_verdict();
        end
    end
    initial
    begin
        cyc(16);
        rst = 1'b0;
        acc(5, 1'b1, 8'h08, 16'h0000);
        for (int e = 1; e < 16; e++)
        begin
            seed = xorshift(seed);
            // Endpoints up to 8 get enabled later, so their sizes stay small
            sizes[e] = {seed[15:13], 2'(e % 3), (e > 8 ? seed[10:9] : 2'b00), seed[8:0]};
            acc(e, 1'b0, 8'h04, sizes[e]);
            cyc(2);
            chk(count, sizes[e] & 16'h07ff);
            chk(16'(fifo_size), sizes[e] & 16'h07ff);
        end
        acc(0, 1'b0, 8'h04, 16'h07ff);
        for (int e = 0; e < 16; e++)
            acc(e, 1'b1, 8'h04, sizes[e] & 16'h1fff);
        acc(1, 1'b1, 8'h0c, 16'h0000);
        for (int k = 0; k < 8; k++)
        begin
            seed = xorshift(seed);
            tword = {seed[15:5], 2'b01, 3'(k)};
            acc(k + 1, 1'b0, 8'h08, tword);
            cyc(1);
            chk(16'({ep_type, dbl_en}), 16'({tword[1:0], tword[2]}));
            chk(16'({ep_enable, allocated[k + 1], toggle_seen[k + 1]}), 16'h0007);
            chk(16'(packets), 16'(k[0] ? sizes[k + 1][12:11] : 2'b00));
            acc(k + 1, 1'b1, 8'h08, tword & 16'h001f);
        end
        high_speed = 1'b0;
        acc(2, 1'b1, 8'h08, 16'h0009);
        chk(16'(packets), 16'h0000);
        high_speed = 1'b1;
        fire(2'b10);
        fire(2'b01);
        chk(zlps, 16'h0001);
        acc(2, 1'b0, 8'h08, 16'h0019);
        fire(2'b10);
        fire(2'b01);
        chk(zlps, 16'h0001);
        acc(3, 1'b0, 8'h08, 16'h0002);
        cyc(1);
        chk(16'(allocated[3]), 16'h0000);
        toggle_seen = 16'h0000;
        acc(3, 1'b0, 8'h08, 16'h000a);
        cyc(1);
        chk(toggle_seen, 16'h0008);
        len_wr = 1'b1;
        cyc(1);
        len_wr = 1'b0;
        cyc(2);
        chk(count, len_wdata);
        acc(3, 1'b0, 8'h04, sizes[3]);
        cyc(2);
        chk(count, sizes[3] & 16'h07ff);
        bus_reset = 1'b1;
        cyc(3);
        bus_reset = 1'b0;
        chk(count, 16'h0000);
        print_verdict();
    end
endmodule : endpoint_config_regs_test
`default_nettype wire
